// *** iot_pkg.sv ***
/*
  Shared constants, field layout and carrier types for the I/O inactivity
  timeout and system management interrupt auxiliary logic.
  Assumes one 125 MHz clock and an APB register port with 32-bit data.
*/
package iot_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_AUX_CTRL = 16'h5472;
  localparam logic [15:0] IDX_TIMEOUT_CNT2 = 16'hAC72;
  localparam int ADDR_W = 18;
  localparam int REG_W = 16;
  localparam logic [REG_W-1:0] AUX_RESET = 16'h0000;
  localparam logic [REG_W-1:0] CNT2_RESET = 16'h0000;
  // Software-writable bits of the auxiliary register.
  localparam logic [REG_W-1:0] AUX_WR_MASK = 16'hAF3F;

  // Timeout count register 2 layout.
  localparam int CNT_W = 5;
  localparam int C2_TEST_BIT = 15;
  localparam int C2_SPB_LSB = 10;
  localparam int C2_PAR_LSB = 5;
  localparam int C2_CS1_SEL_BIT = 4;
  localparam int C2_CS2_SEL_BIT = 3;
  localparam int C2_SPA_SEL_BIT = 2;
  localparam int C2_SPB_SEL_BIT = 1;
  localparam int C2_PAR_SEL_BIT = 0;

  // Auxiliary control register layout.
  localparam int AUX_MASK_BIT = 15;
  localparam int AUX_WDEN_BIT = 13;
  localparam int AUX_WDST_BIT = 12;
  localparam int AUX_CS3M_BIT = 11;
  localparam int AUX_CS2M_BIT = 10;
  localparam int AUX_TPE_BIT = 9;
  localparam int AUX_TOE_BIT = 8;
  localparam int AUX_TOS_BIT = 7;
  localparam int AUX_ADS_BIT = 6;
  localparam int AUX_CS3_LSB = 1;
  localparam int AUX_CS3_SEL_BIT = 0;

  // Time base: the timers tick at half the step so the error stays within half a step.
  localparam longint CLK_HZ = 125_000_000;
  localparam int FAST_STEP_S = 4;
  localparam int SLOW_STEP_S = 40;
  localparam int HALF_FAST_CYCLES = int'((longint'(FAST_STEP_S) * CLK_HZ) / 2);
  localparam int SLOW_PER_FAST = SLOW_STEP_S / FAST_STEP_S;
  localparam int WDOG_PERIOD_US = 125_000;
  localparam int WDOG_HALF_CYCLES = int'((longint'(WDOG_PERIOD_US) * CLK_HZ) / 64'd2_000_000);
  localparam int TICK_W = 6;

  // APB answer for unmapped addresses.
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  typedef enum logic [1:0] {
    IOT_SEL_NONE = 2'b00,
    IOT_SEL_AUX = 2'b01,
    IOT_SEL_CNT2 = 2'b11
  } iot_regsel_t;

  // Access strobes from the host I/O decode, one cycle per I/O cycle.
  typedef struct packed {
    logic serial_b;
    logic parallel;
    logic cs_two;
    logic cs_three;
  } iot_access_t;

  // Clock selects for channels whose timers live elsewhere in the controller.
  typedef struct packed {
    logic chip_select_one_clock_select;
    logic chip_select_two_clock_select;
    logic serial_a_clock_select;
  } iot_ext_sel_t;

  // Activity monitor feed and trap request, registered.
  typedef struct packed {
    logic cs_two_activity;
    logic cs_three_activity;
    logic cs_three_trap;
  } iot_monitor_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

endpackage : iot_pkg

// *** iot_chan_timer.sv ***
/*
  One inactivity timeout channel: counts half-step ticks down from a
  loaded value and pulses on expiry.
  Assumes fast and slow tick enables are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module iot_chan_timer #(
  parameter int TICK_W = iot_pkg::TICK_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [iot_pkg::CNT_W-1:0] count,
  input wire logic slow_sel,
  input wire logic fast_tick,
  input wire logic slow_tick,
  input wire logic reload,
  output logic expired
);

  logic [TICK_W-1:0] remain_r;
  logic armed_r;
  logic tick;
  logic [TICK_W-1:0] load_val;

  // Two half ticks per step plus one: the partial first tick never shortens the period.
  assign load_val = {count, 1'b1};
  assign tick = slow_sel ? slow_tick : fast_tick;

  // Down counter; activity or a fresh enable restarts it from the full count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain_r <= '0;
      armed_r <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (!enable) begin
        remain_r <= load_val;
        armed_r <= 1'b1;
      end else if (reload) begin
        remain_r <= load_val;
        armed_r <= 1'b1;
      end else if (armed_r && tick) begin
        if (remain_r <= TICK_W'(1)) begin
          remain_r <= '0;
          armed_r <= 1'b0;
          expired <= 1'b1;
        end else begin
          remain_r <= remain_r - TICK_W'(1);
        end
      end
    end
  end

endmodule : iot_chan_timer
`default_nettype wire

// *** iot_timeout_smi.sv ***
/*
  I/O inactivity timeout and system management interrupt auxiliary logic:
  count register 2, auxiliary control register, serial port B, parallel
  port and chip select three timers, the watchdog and the monitor feed.
  Assumes an APB master on pclk, and access strobes from the host I/O
  decode that are already qualified against each address range.
*/
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module iot_timeout_smi #(
  parameter int HALF_FAST_CYCLES = iot_pkg::HALF_FAST_CYCLES,
  parameter int WDOG_HALF_CYCLES = iot_pkg::WDOG_HALF_CYCLES,
  parameter int SLOW_PER_FAST = iot_pkg::SLOW_PER_FAST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [iot_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire iot_pkg::iot_access_t io_access,
  input wire logic serial_b_timeout_enable,
  input wire logic parallel_timeout_enable,
  output logic serial_b_timeout_status,
  output logic parallel_timeout_status,
  output logic system_mgmt_interrupt,
  output logic local_attention_flag,
  output logic watchdog_irq_status,
  output logic counter_test_mode,
  output iot_pkg::iot_ext_sel_t ext_clock_select,
  output iot_pkg::iot_monitor_t monitor
);

  // Register storage.
  logic [iot_pkg::REG_W-1:0] cnt2_r;
  logic [iot_pkg::REG_W-1:0] aux_r;
  logic [iot_pkg::REG_W-1:0] aux_nxt;
  logic cs3_tos_r;
  logic cs3_ads_r;
  logic wd_status_r;

  // Bus decode.
  iot_pkg::iot_regsel_t sel;
  logic setup_phase;
  logic wr_en;
  logic [31:0] rdata_r;
  logic err_r;

  // Time base.
  logic [31:0] fast_cnt_r;
  logic [7:0] slow_cnt_r;
  logic fast_base;
  logic fast_tick;
  logic slow_tick;

  // Watchdog.
  logic [31:0] wd_cnt_r;
  logic wd_half;
  logic wd_phase_r;
  logic wd_fire;

  // Channel views.
  logic mask;
  logic wd_en;
  logic cs3_toe;
  logic spb_exp;
  logic par_exp;
  logic cs3_exp;
  logic spb_tos_r;
  logic par_tos_r;

  // Merge the written byte lanes of a 16-bit register over its old value.
  function automatic logic [iot_pkg::REG_W-1:0] lane_merge(
    input logic [iot_pkg::REG_W-1:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [iot_pkg::REG_W-1:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : lane_merge

  // Address to register select; anything else answers with an error.
  function automatic iot_pkg::iot_regsel_t decode(input logic [iot_pkg::ADDR_W-1:0] addr);
    if (addr == iot_pkg::byte_addr(iot_pkg::IDX_AUX_CTRL)) begin
      return iot_pkg::IOT_SEL_AUX;
    end else if (addr == iot_pkg::byte_addr(iot_pkg::IDX_TIMEOUT_CNT2)) begin
      return iot_pkg::IOT_SEL_CNT2;
    end else begin
      return iot_pkg::IOT_SEL_NONE;
    end
  endfunction : decode

  assign sel = decode(paddr);
  assign setup_phase = psel && !penable;
  // The slave never inserts wait states, so every access phase completes at once.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign prdata = rdata_r;
  assign pslverr = psel && penable && err_r;

  assign mask = aux_r[iot_pkg::AUX_MASK_BIT];
  assign wd_en = aux_r[iot_pkg::AUX_WDEN_BIT];
  assign cs3_toe = aux_r[iot_pkg::AUX_TOE_BIT];
  assign counter_test_mode = cnt2_r[iot_pkg::C2_TEST_BIT];

  // Read data and error are captured in the setup cycle, so the bus sees flop outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= iot_pkg::RDATA_NONE;
      err_r <= 1'b0;
    end else if (setup_phase) begin
      err_r <= (sel == iot_pkg::IOT_SEL_NONE);
      case (sel)
        iot_pkg::IOT_SEL_AUX: begin
          rdata_r <= {16'h0000, aux_r[15:13], wd_status_r, aux_r[11:8], cs3_tos_r, cs3_ads_r,
                      aux_r[5:0]};
        end
        iot_pkg::IOT_SEL_CNT2: begin
          rdata_r <= {16'h0000, cnt2_r};
        end
        default: begin
          rdata_r <= iot_pkg::RDATA_NONE;
        end
      endcase
    end
  end

  // Count register 2 holds the test bit, two counts and five clock selects.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt2_r <= iot_pkg::CNT2_RESET;
    end else if (wr_en && sel == iot_pkg::IOT_SEL_CNT2) begin
      cnt2_r <= lane_merge(cnt2_r, pwdata, pstrb);
    end
  end

  // Only writable bits of the auxiliary register are stored; status bits live apart.
  always_comb begin
    aux_nxt = aux_r;
    if (wr_en && sel == iot_pkg::IOT_SEL_AUX) begin
      aux_nxt = lane_merge(aux_r, pwdata, pstrb) & iot_pkg::AUX_WR_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_r <= iot_pkg::AUX_RESET;
    end else begin
      aux_r <= aux_nxt;
    end
  end

  // Fast half-step base tick, free running from reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_cnt_r <= '0;
    end else if (fast_base) begin
      fast_cnt_r <= '0;
    end else begin
      fast_cnt_r <= fast_cnt_r + 32'd1;
    end
  end

  assign fast_base = (fast_cnt_r >= 32'(HALF_FAST_CYCLES - 1));

  // Slow half-step tick is every tenth fast one, keeping both grids aligned.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt_r <= '0;
    end else if (fast_base) begin
      if (slow_cnt_r >= 8'(SLOW_PER_FAST - 1)) begin
        slow_cnt_r <= '0;
      end else begin
        slow_cnt_r <= slow_cnt_r + 8'd1;
      end
    end
  end

  // Test mode makes every cycle a tick so a tester can walk a count out quickly.
  assign fast_tick = counter_test_mode || fast_base;
  assign slow_tick = counter_test_mode || (fast_base && slow_cnt_r >= 8'(SLOW_PER_FAST - 1));

  // Serial port B channel; activity is ignored while the mask is set.
  iot_chan_timer u_spb (
    .pclk(pclk),
    .presetn(presetn),
    .enable(serial_b_timeout_enable),
    .count(cnt2_r[iot_pkg::C2_SPB_LSB +: iot_pkg::CNT_W]),
    .slow_sel(cnt2_r[iot_pkg::C2_SPB_SEL_BIT]),
    .fast_tick(fast_tick),
    .slow_tick(slow_tick),
    .reload(io_access.serial_b && !mask),
    .expired(spb_exp)
  );

  // Parallel port channel.
  iot_chan_timer u_par (
    .pclk(pclk),
    .presetn(presetn),
    .enable(parallel_timeout_enable),
    .count(cnt2_r[iot_pkg::C2_PAR_LSB +: iot_pkg::CNT_W]),
    .slow_sel(cnt2_r[iot_pkg::C2_PAR_SEL_BIT]),
    .fast_tick(fast_tick),
    .slow_tick(slow_tick),
    .reload(io_access.parallel && !mask),
    .expired(par_exp)
  );

  // Chip select three channel; reload does not depend on the chip select being enabled.
  iot_chan_timer u_cs3 (
    .pclk(pclk),
    .presetn(presetn),
    .enable(cs3_toe),
    .count(aux_r[iot_pkg::AUX_CS3_LSB +: iot_pkg::CNT_W]),
    .slow_sel(aux_r[iot_pkg::AUX_CS3_SEL_BIT]),
    .fast_tick(fast_tick),
    .slow_tick(slow_tick),
    .reload(io_access.cs_three && !mask),
    .expired(cs3_exp)
  );

  // Timeout statuses: expiry sets, clearing the channel enable clears.
  // The mask does not stop them being set, which is how a masked timeout is held.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spb_tos_r <= 1'b0;
      par_tos_r <= 1'b0;
    end else begin
      spb_tos_r <= serial_b_timeout_enable && (spb_tos_r || spb_exp);
      par_tos_r <= parallel_timeout_enable && (par_tos_r || par_exp);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs3_tos_r <= 1'b0;
    end else if (!aux_nxt[iot_pkg::AUX_TOE_BIT]) begin
      cs3_tos_r <= 1'b0;
    end else if (cs3_exp) begin
      cs3_tos_r <= 1'b1;
    end
  end

  // Activity after a timeout tells the handler to restart rather than power down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs3_ads_r <= 1'b0;
    end else if (!aux_nxt[iot_pkg::AUX_TOE_BIT]) begin
      cs3_ads_r <= 1'b0;
    end else if (cs3_tos_r && io_access.cs_three) begin
      cs3_ads_r <= 1'b1;
    end
  end

  assign serial_b_timeout_status = spb_tos_r;
  assign parallel_timeout_status = par_tos_r;

  // The interrupt is a registered function of held statuses, so unmasking releases it one cycle later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_mgmt_interrupt <= 1'b0;
    end else begin
      system_mgmt_interrupt <= !mask && (spb_tos_r || par_tos_r || cs3_tos_r);
    end
  end

  // Watchdog half-period base runs freely whether the watchdog is enabled or not.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= '0;
    end else if (wd_half) begin
      wd_cnt_r <= '0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 32'd1;
    end
  end

  assign wd_half = (wd_cnt_r >= 32'(WDOG_HALF_CYCLES - 1));

  // Events come on every second half period once enabled, so the first lands late in
  // the first full period and never sooner than half of it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_phase_r <= 1'b0;
    end else if (!wd_en) begin
      wd_phase_r <= 1'b0;
    end else if (wd_half) begin
      wd_phase_r <= !wd_phase_r;
    end
  end

  assign wd_fire = wd_en && wd_half && wd_phase_r;

  // Watchdog status: an event wins over a zero written in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_status_r <= 1'b0;
    end else if (!aux_nxt[iot_pkg::AUX_WDEN_BIT]) begin
      wd_status_r <= 1'b0;
    end else if (wd_fire) begin
      wd_status_r <= 1'b1;
    end else if (wr_en && sel == iot_pkg::IOT_SEL_AUX && pstrb[1] &&
                 !pwdata[iot_pkg::AUX_WDST_BIT]) begin
      wd_status_r <= 1'b0;
    end
  end

  assign watchdog_irq_status = wd_status_r;

  // Attention pulse for each watchdog event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_attention_flag <= 1'b0;
    end else begin
      local_attention_flag <= wd_fire;
    end
  end

  // Monitor feed and trap: chip select enables play no part here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor <= '0;
    end else begin
      monitor.cs_two_activity <= io_access.cs_two && !aux_r[iot_pkg::AUX_CS2M_BIT];
      monitor.cs_three_activity <= io_access.cs_three && !aux_r[iot_pkg::AUX_CS3M_BIT];
      monitor.cs_three_trap <= io_access.cs_three && aux_r[iot_pkg::AUX_TPE_BIT];
    end
  end

  // Clock selects for timers held elsewhere, in one assignment so the port has a single driver.
  assign ext_clock_select = {cnt2_r[iot_pkg::C2_CS1_SEL_BIT], cnt2_r[iot_pkg::C2_CS2_SEL_BIT],
                             cnt2_r[iot_pkg::C2_SPA_SEL_BIT]};

endmodule : iot_timeout_smi
`default_nettype wire

// *** iot_smi_properties.sv ***
/*
  Checker for the I/O timeout and SMI block; it sees only the top ports.
  Assumes the bench binds it with the block's watchdog parameter.
*/
`timescale 1ns/1ns
`default_nettype none
module iot_smi_props #(
  parameter int WDOG_HALF_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [iot_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire iot_pkg::iot_access_t io_access,
  input wire logic serial_b_timeout_status,
  input wire logic parallel_timeout_status,
  input wire logic system_mgmt_interrupt,
  input wire logic local_attention_flag,
  input wire logic watchdog_irq_status,
  input wire logic counter_test_mode,
  input wire iot_pkg::iot_monitor_t monitor
);
  localparam int WD_P = 2 * WDOG_HALF_CYCLES;
  localparam int WD_LO = WDOG_HALF_CYCLES - 2;
  localparam int WD_HI = WD_P + 2;
  logic aux_wr, cnt_wr, seen_r;
  logic [7:0] hi_r;
  logic [7:0] gap_r;

  // Upper-lane writes as the slave takes them; lane 1 holds every control bit we shadow.
  assign aux_wr = psel && penable && pwrite && pstrb[1] && paddr == {iot_pkg::IDX_AUX_CTRL, 2'b00};
  assign cnt_wr = psel && penable && pwrite && pstrb[1] && paddr == {iot_pkg::IDX_TIMEOUT_CNT2, 2'b00};

  // Shadow of auxiliary bits 15:8.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_r <= 8'h00;
    end else if (aux_wr) begin
      hi_r <= pwdata[15:8];
    end
  end

  // Cycles since the last watchdog pulse; cleared while disabled, since the base runs free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else if (!hi_r[5]) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r <= local_attention_flag ? 8'h01 : gap_r + {7'h00, gap_r != 8'hFF};
      seen_r <= seen_r | local_attention_flag;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  test_mode_a: assert property (cnt_wr |=> counter_test_mode == $past(pwdata[15]))
    else $error("test mode bit not taken");
  smi_mask_a: assert property (hi_r[7] && $past(hi_r[7]) |-> !system_mgmt_interrupt)
    else $error("interrupt while masked");
  smi_raise_a: assert property (((serial_b_timeout_status || parallel_timeout_status) && !hi_r[7])[*3]
    |-> system_mgmt_interrupt) else $error("unmasked timeout gave no interrupt");
  wdog_first_a: assert property (local_attention_flag && hi_r[5] && !seen_r |-> gap_r >= WD_LO && gap_r <= WD_HI)
    else $error("first watchdog pulse out of window");
  wdog_period_a: assert property (local_attention_flag && seen_r |-> gap_r == WD_P)
    else $error("watchdog period wrong");
  wdog_off_a: assert property (!hi_r[5] |-> !watchdog_irq_status)
    else $error("watchdog status while disabled");
  cs2_hide_a: assert property (monitor.cs_two_activity == ($past(io_access.cs_two) && !$past(hi_r[2])))
    else $error("chip select two activity feed wrong");
  cs3_hide_a: assert property (monitor.cs_three_activity == ($past(io_access.cs_three) && !$past(hi_r[3])))
    else $error("chip select three activity feed wrong");
  trap_fire_a: assert property (monitor.cs_three_trap == ($past(io_access.cs_three) && $past(hi_r[1])))
    else $error("trap request wrong");

  cover property ($rose(system_mgmt_interrupt));
  cover property (monitor.cs_three_trap);
  cover property (local_attention_flag && seen_r);
endmodule : iot_smi_props
`default_nettype wire

// *** iot_host_model.sv ***
/*
  Host I/O cycle model: turns bench requests into one-cycle range strobes.
  Assumes the bench changes run, gap and lanes just after rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module iot_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [7:0] gap,
  input wire iot_pkg::iot_access_t lanes,
  output iot_pkg::iot_access_t io_access
);
  logic [7:0] wait_r;

  // One I/O cycle every gap+1 clocks while run is high; strobes never stretch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 8'h00;
      io_access <= 4'h0;
    end else if (run && wait_r == 8'h00) begin
      io_access <= lanes;
      wait_r <= gap;
    end else begin
      io_access <= 4'h0;
      wait_r <= run ? wait_r - 8'h01 : 8'h00;
    end
  end
endmodule : iot_host_model
`default_nettype wire

// *** iot_tb.sv ***
/*
  Self-checking bench for the I/O timeout and SMI block, with host model and checker.
  Assumes shortened timer and watchdog parameters.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  localparam int HF = 20;
  localparam int WH = 10;
  localparam int SPF = 10;
  localparam logic [17:0] A_AUX = {iot_pkg::IDX_AUX_CTRL, 2'b00};
  localparam logic [17:0] A_CNT = {iot_pkg::IDX_TIMEOUT_CNT2, 2'b00};
  localparam logic [15:0] MC [3] = '{16'h0000, 16'h0C00, 16'h0200};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sb_en = 1'b0, par_en = 1'b0, run = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] gap = 8'h00;
  iot_pkg::iot_access_t lanes = 4'h0;
  iot_pkg::iot_access_t io_access;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, sb_st, par_st, smi, flag, wd_st, test_mode;
  iot_pkg::iot_ext_sel_t ext_sel;
  iot_pkg::iot_monitor_t mon;
  int err_count = 0;
  int n_tests = 0;
  int k;

  // Free-running 125 MHz clock.
  always #4 pclk = ~pclk;

  iot_timeout_smi #(.HALF_FAST_CYCLES(HF), .WDOG_HALF_CYCLES(WH), .SLOW_PER_FAST(SPF)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_access(io_access), .serial_b_timeout_enable(sb_en), .parallel_timeout_enable(par_en),
    .serial_b_timeout_status(sb_st), .parallel_timeout_status(par_st), .system_mgmt_interrupt(smi),
    .local_attention_flag(flag), .watchdog_irq_status(wd_st), .counter_test_mode(test_mode),
    .ext_clock_select(ext_sel), .monitor(mon));
  iot_host_model host (.pclk(pclk), .presetn(presetn), .run(run), .gap(gap), .lanes(lanes),
    .io_access(io_access));

  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [17:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask : wr

  task rdchk(input logic [17:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK(rd, {16'h0000, e})
  endtask : rdchk

  // Waits for a status or the watchdog pulse; running out of cycles ends the run.
  task wait_sig(input int w, input int lim, output int c);
    logic s;
    c = 0;
    do begin
      @(negedge pclk);
      c++;
      s = w == 0 ? sb_st : w == 1 ? par_st : flag;
    end while (s !== 1'b1 && c < lim);
    if (s !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask : wait_sig

  // A single host I/O cycle; returns once the monitor response has settled.
  task pulse(input iot_pkg::iot_access_t l);
    @(posedge pclk);
    lanes <= l;
    gap <= 8'h00;
    run <= 1'b1;
    @(posedge pclk);
    run <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask : pulse

  // Expiry time of one channel against count and step; under the mask, accesses keep coming.
  task chan(input int ch, input logic sel, input int n, input logic msk);
    int c, half;
    half = sel ? HF * SPF : HF;
    wr(A_CNT, ch == 0 ? {1'b0, 5'(n), 8'h00, sel, 1'b0} : {6'h00, 5'(n), 4'h0, sel});
    wr(A_AUX, {msk, 15'h0000});
    lanes <= ch == 0 ? 4'h8 : 4'h4;
    gap <= 8'h09;
    run <= msk;
    if (ch == 0) sb_en <= 1'b1;
    else par_en <= 1'b1;
    wait_sig(ch, 2000, c);
    `CHK(c >= 2 * n * half && c <= (2 * n + 1) * half + 4, 1'b1)
    @(posedge pclk);
    run <= 1'b0;
    repeat (2) @(negedge pclk);
    `CHK(smi, !msk)
    if (msk) begin
      wr(A_AUX, 16'h0000);
      repeat (3) @(negedge pclk);
      `CHK(smi, 1'b1)
    end
    @(posedge pclk);
    sb_en <= 1'b0;
    par_en <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : chan

  // Main sequence.
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_AUX, 16'h0000);
    rdchk(A_CNT, 16'h0000);
    apb(1'b0, 18'h00000, 32'h00000000);
    `CHK({er, rd}, {1'b1, iot_pkg::RDATA_NONE})
    wr(A_CNT, 16'hFFFF);
    rdchk(A_CNT, 16'hFFFF);
    `CHK({test_mode, ext_sel}, 4'hF)
    sb_en <= 1'b1;
    wait_sig(0, 70, k);
    @(posedge pclk);
    sb_en <= 1'b0;
    wr(A_CNT, 16'h0000);
    wr(A_AUX, 16'hFFFF);
    rdchk(A_AUX, 16'hAF3F);
    for (int ch = 0; ch < 2; ch++) begin
      for (int s = 0; s < 2; s++) begin
        chan(ch, s[0], s ? 1 : 3, 1'b0);
      end
    end
    chan(1, 1'b0, 1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(A_AUX, MC[i]);
      pulse(4'h3);
      `CHK(mon, {~MC[i][10], ~MC[i][11], MC[i][9]})
    end
    wr(A_AUX, 16'h0102);
    lanes <= 4'h1;
    gap <= 8'h18;
    run <= 1'b1;
    repeat (150) @(posedge pclk);
    run <= 1'b0;
    rdchk(A_AUX, 16'h0102);
    repeat (80) @(posedge pclk);
    rdchk(A_AUX, 16'h0182);
    `CHK(smi, 1'b1)
    pulse(4'h1);
    rdchk(A_AUX, 16'h01C2);
    wr(A_AUX, 16'h0002);
    rdchk(A_AUX, 16'h0002);
    wr(A_AUX, 16'h2000);
    wait_sig(2, 3 * WH, k);
    `CHK(k >= WH - 2 && k <= 2 * WH + 2, 1'b1)
    `CHK(wd_st, 1'b1)
    wr(A_AUX, 16'h3000);
    @(negedge pclk);
    `CHK(wd_st, 1'b1)
    wr(A_AUX, 16'h2000);
    @(negedge pclk);
    `CHK(wd_st, 1'b0)
    wait_sig(2, 2 * WH + 2, k);
    `CHK(wd_st, 1'b1)
    wr(A_AUX, 16'h0000);
    @(negedge pclk);
    `CHK(wd_st, 1'b0)
    k = 0;
    repeat (3 * WH) begin
      @(negedge pclk);
      if (flag !== 1'b0) k++;
    end
    `CHK(k, 0)
    stop_test();
  end

  // Hang guard far beyond the longest scenario, yet well inside the cycle budget.
  initial begin
    #400000;
    err_count++;
    stop_test();
  end
endmodule : tb

bind iot_timeout_smi iot_smi_props #(.WDOG_HALF_CYCLES(WDOG_HALF_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .io_access(io_access), .serial_b_timeout_status(serial_b_timeout_status),
  .parallel_timeout_status(parallel_timeout_status), .system_mgmt_interrupt(system_mgmt_interrupt),
  .local_attention_flag(local_attention_flag), .watchdog_irq_status(watchdog_irq_status),
  .counter_test_mode(counter_test_mode), .monitor(monitor));
`default_nettype wire
